/* rtl/dsc_regs.sv */
// register bank seen by the disk-side processor: general and drive status/control
module dsc_regs
    import dsc_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       nrst,
    input  wire logic       clk_en,
    input  wire logic [7:0] io_addr,
    input  wire logic [7:0] io_wdata,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    input  wire logic       cpu_a15,
    input  wire logic       irq_to_secondary_cpu_n,
    input  wire logic       irq_to_main_cpu_n,
    input  wire logic       drive_ready_n,
    input  wire logic       head_dir_n,
    input  wire logic       track_zero_flag,
    input  wire logic       write_gate_n,
    input  wire logic       head_step_n,
    input  wire logic       inner_track_flag_n,
    input  wire logic       fc_irq,
    input  wire logic       transfer_request,
    output logic [7:0]      io_rdata,
    output logic            mem_a15,
    output logic            addr_invert_bit,
    output logic            diag_lamp_lsb,
    output logic            diag_lamp_mid,
    output logic            diag_lamp_msb,
    output logic [1:0]      drive_select_field,
    output logic            fc_ready_n,
    output logic            motor0_on_n,
    output logic            motor1_on_n,
    output logic            side_select,
    output logic [1:0]      precomp_select
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic is_gen(input logic [7:0] a);
        is_gen = (a == DSC_FLIP_LED_CTRL_OFS) || (a == DSC_GEN_STAT_OFS);
    endfunction

    logic       flip_q, flip_d;
    logic [2:0] led_q, led_d;
    logic [7:0] drv_q, drv_d;
    logic [7:0] rdata_q, rdata_d;
    logic       a15_q, a15_d;
    logic       rdy_q, rdy_d;

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_comb begin
        flip_d = flip_q;
        led_d  = led_q;
        drv_d  = drv_q;
        if (clk_en && io_wr && is_gen(io_addr)) begin
            flip_d = io_addr[0];
            led_d  = io_wdata[DSC_LED_HI_POS:DSC_LED_LO_POS];
        end
        if (clk_en && io_wr && io_addr == DSC_DRV_OFS) begin
            drv_d = io_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            flip_q <= DSC_FLIP_RST;
            led_q  <= DSC_LED_RST;
            drv_q  <= DSC_DRV_CTRL_RST;
        end else begin
            flip_q <= flip_d;
            led_q  <= led_d;
            drv_q  <= drv_d;
        end
    end

    // ------------------------------------------------------------
    // read path and pin outputs
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = rdata_q;
        a15_d   = a15_q;
        rdy_d   = rdy_q;
        if (clk_en) begin
            // flip low moves the private ram up to 8000H
            a15_d = flip_q ? cpu_a15 : ~cpu_a15;
            // the override only ever asserts ready, never hides a real one
            rdy_d = drive_ready_n & ~drv_q[DSC_SETRDY_POS];
            rdata_d = DSC_RD_IDLE;
            if (io_rd && io_addr == DSC_GEN_STAT_OFS) begin
                rdata_d = {head_step_n, write_gate_n, track_zero_flag, head_dir_n,
                           drive_ready_n, irq_to_main_cpu_n, irq_to_secondary_cpu_n,
                           flip_q};
            end else if (io_rd && io_addr == DSC_DRV_OFS) begin
                rdata_d = {transfer_request, fc_irq, drv_q[DSC_SIDE_POS],
                           ~drv_q[DSC_MOT1_POS], ~drv_q[DSC_MOT0_POS],
                           inner_track_flag_n,
                           drv_q[DSC_DS_HI_POS:DSC_DS_LO_POS]};
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rdata_q <= DSC_RD_IDLE;
            a15_q   <= DSC_A15_RST;
            rdy_q   <= DSC_RDY_RST;
        end else begin
            rdata_q <= rdata_d;
            a15_q   <= a15_d;
            rdy_q   <= rdy_d;
        end
    end

    assign io_rdata           = rdata_q;
    assign mem_a15            = a15_q;
    assign fc_ready_n         = rdy_q;
    assign addr_invert_bit    = flip_q;
    assign diag_lamp_lsb      = led_q[0];
    assign diag_lamp_mid      = led_q[1];
    assign diag_lamp_msb      = led_q[2];
    assign drive_select_field = drv_q[DSC_DS_HI_POS:DSC_DS_LO_POS];
    assign motor0_on_n        = ~drv_q[DSC_MOT0_POS];
    assign motor1_on_n        = ~drv_q[DSC_MOT1_POS];
    assign side_select        = drv_q[DSC_SIDE_POS];
    assign precomp_select     = drv_q[DSC_PC_HI_POS:DSC_PC_LO_POS];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    flip_set_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && io_wr && io_addr == DSC_GEN_STAT_OFS |=> addr_invert_bit)
        else $error("flip not set by write at 21H");
    flip_clr_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && io_wr && io_addr == DSC_FLIP_LED_CTRL_OFS |=> !addr_invert_bit)
        else $error("flip not cleared by write at 20H");
    lamp_load_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && io_wr && is_gen(io_addr) |=>
        diag_lamp_msb == $past(io_wdata[6]) && diag_lamp_lsb == $past(io_wdata[4]))
        else $error("lamp bits not loaded");
    a15_inv_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && !addr_invert_bit && $stable(addr_invert_bit) |=> mem_a15 == !$past(cpu_a15))
        else $error("address line 15 not inverted");
    gen_read_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && io_rd && io_addr == DSC_GEN_STAT_OFS |=>
        io_rdata[0] == $past(addr_invert_bit) && io_rdata[7] == $past(head_step_n)
        && io_rdata[5] == $past(track_zero_flag))
        else $error("general status read wrong");
    drv_read_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && io_rd && io_addr == DSC_DRV_OFS |=>
        io_rdata[1:0] == $past(drive_select_field) && io_rdata[3] == $past(motor0_on_n)
        && io_rdata[7] == $past(transfer_request))
        else $error("drive status read wrong");
    drv_load_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && io_wr && io_addr == DSC_DRV_OFS |=>
        motor1_on_n == !$past(io_wdata[4]) && precomp_select == $past(io_wdata[7:6]))
        else $error("drive control not loaded");
    ready_force_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && drv_q[DSC_SETRDY_POS] |=> !fc_ready_n)
        else $error("ready override ignored");

    // ------------------------------------------------------------
    // status read checks
    // ------------------------------------------------------------
    stat_ready_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && io_rd && io_addr == DSC_GEN_STAT_OFS |=>
        io_rdata[3] == $past(drive_ready_n))
        else $error("status bit 3 does not follow ready line");

    stat_dir_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && io_rd && io_addr == DSC_GEN_STAT_OFS |=>
        io_rdata[4] == $past(head_dir_n))
        else $error("status bit 4 does not follow head direction");

    stat_step_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && io_rd && io_addr == DSC_GEN_STAT_OFS |=>
        io_rdata[7] == $past(head_step_n))
        else $error("status bit 7 does not follow step line");

    stat_gate_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && io_rd && io_addr == DSC_GEN_STAT_OFS |=>
        io_rdata[6] == $past(write_gate_n))
        else $error("status bit 6 does not follow write gate");

    stat_irq_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && io_rd && io_addr == DSC_GEN_STAT_OFS |=>
        io_rdata[2:1] == {$past(irq_to_main_cpu_n), $past(irq_to_secondary_cpu_n)})
        else $error("status interrupt bits wrong");

    drv_motor_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && io_rd && io_addr == DSC_DRV_OFS |=>
        io_rdata[5:3] == {$past(side_select), $past(motor1_on_n), $past(motor0_on_n)})
        else $error("drive status motor or side bits wrong");

    drv_fc_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && io_rd && io_addr == DSC_DRV_OFS |=>
        io_rdata[7:6] == {$past(transfer_request), $past(fc_irq)})
        else $error("drive status controller bits wrong");

    drv_inner_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && io_rd && io_addr == DSC_DRV_OFS |=>
        io_rdata[2] == $past(inner_track_flag_n))
        else $error("drive status inner track bit wrong");

    rd_idle_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && !(io_rd && (io_addr == DSC_GEN_STAT_OFS || io_addr == DSC_DRV_OFS)) |=>
        io_rdata == DSC_RD_IDLE)
        else $error("read data not idle");

    // ------------------------------------------------------------
    // control write and pass-through checks
    // ------------------------------------------------------------
    lamp_mid_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && io_wr && is_gen(io_addr) |=>
        diag_lamp_mid == $past(io_wdata[5]))
        else $error("middle lamp bit not loaded");

    lamp_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        !(clk_en && io_wr && is_gen(io_addr)) |=>
        $stable(diag_lamp_lsb) && $stable(diag_lamp_mid) && $stable(diag_lamp_msb))
        else $error("lamps changed without a control write");

    flip_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        !(clk_en && io_wr && is_gen(io_addr)) |=>
        $stable(addr_invert_bit))
        else $error("flip changed without a control write");

    gen_isolate_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && io_wr && is_gen(io_addr) |=>
        $stable(drive_select_field) && $stable(precomp_select) && $stable(side_select))
        else $error("general write disturbed drive control");

    drv_isolate_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && io_wr && io_addr == DSC_DRV_OFS |=>
        $stable(addr_invert_bit) && $stable(diag_lamp_mid))
        else $error("drive write disturbed general control");

    drv_sel_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && io_wr && io_addr == DSC_DRV_OFS |=>
        drive_select_field == $past(io_wdata[1:0]))
        else $error("drive select not loaded");

    side_load_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && io_wr && io_addr == DSC_DRV_OFS |=>
        side_select == $past(io_wdata[5]))
        else $error("side select not loaded");

    motor0_load_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && io_wr && io_addr == DSC_DRV_OFS |=>
        motor0_on_n == !$past(io_wdata[3]))
        else $error("first motor bit not loaded");

    drv_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        !(clk_en && io_wr && io_addr == DSC_DRV_OFS) |=>
        $stable(drive_select_field) && $stable(precomp_select) && $stable(motor1_on_n))
        else $error("drive control changed without a write");

    a15_pass_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && addr_invert_bit |=>
        mem_a15 == $past(cpu_a15))
        else $error("address line 15 not passed through");

    rdy_pass_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        clk_en && !drv_q[DSC_SETRDY_POS] |=>
        fc_ready_n == $past(drive_ready_n))
        else $error("ready line not passed through");

    // ------------------------------------------------------------
    // reset and enable checks
    // ------------------------------------------------------------
    // no disable on the two reset checks: these watch the reset itself
    flip_reset_a: assert property (@(posedge sys_clk)
        !nrst |=>
        !addr_invert_bit)
        else $error("flip not low after reset");

    drv_reset_a: assert property (@(posedge sys_clk)
        !nrst |=>
        motor0_on_n && motor1_on_n && drive_select_field == 2'h0 && !drv_q[DSC_SETRDY_POS])
        else $error("drive control not cleared by reset");

    enable_freeze_a: assert property (@(posedge sys_clk) disable iff (!nrst)
        !clk_en |=>
        $stable(addr_invert_bit) && $stable(drive_select_field) && $stable(io_rdata))
        else $error("state moved while clock enable low");
endmodule

/* rtl/dsc_pkg.sv */
// package: offsets, field positions and reset values of the disk-side register bank
package dsc_pkg;
    // ------------------------------------------------------------
    // i/o offsets
    // ------------------------------------------------------------
    localparam logic [7:0] DSC_FLIP_LED_CTRL_OFS = 8'h20;
    localparam logic [7:0] DSC_GEN_STAT_OFS      = 8'h21;
    localparam logic [7:0] DSC_DRV_OFS           = 8'h40;
    // ------------------------------------------------------------
    // general control fields
    // ------------------------------------------------------------
    localparam int DSC_LED_LO_POS  = 4;
    localparam int DSC_LED_HI_POS  = 6;
    // ------------------------------------------------------------
    // drive control fields
    // ------------------------------------------------------------
    localparam int DSC_DS_LO_POS   = 0;
    localparam int DSC_DS_HI_POS   = 1;
    localparam int DSC_SETRDY_POS  = 2;
    localparam int DSC_MOT0_POS    = 3;
    localparam int DSC_MOT1_POS    = 4;
    localparam int DSC_SIDE_POS    = 5;
    localparam int DSC_PC_LO_POS   = 6;
    localparam int DSC_PC_HI_POS   = 7;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] DSC_DRV_CTRL_RST = 8'h00;
    localparam logic [2:0] DSC_LED_RST      = 3'h7;
    localparam logic       DSC_FLIP_RST     = 1'b0;
    localparam logic       DSC_A15_RST      = 1'h1;
    localparam logic       DSC_RDY_RST      = 1'h1;
    localparam logic [7:0] DSC_RD_IDLE      = 8'h00;
endpackage

/* tb/dsc_far_model.sv */
// far-side model: floppy controller outputs and drive lines
module dsc_far_model (
    input  wire logic [1:0] drive_select_field,
    input  wire logic       motor0_on_n,
    input  wire logic       motor1_on_n,
    input  wire logic [6:0] track,
    input  wire logic [4:0] pat,
    output logic            drive_ready_n,
    output logic            track_zero_flag,
    output logic            inner_track_flag_n,
    output logic [4:0]      fc_lines
);
    timeunit 1ns;
    timeprecision 1ps;
    // a drive only reports ready while its unit motor spins, so a wrong motor bit shows up
    assign drive_ready_n      = drive_select_field[1] ? motor1_on_n : motor0_on_n;
    assign track_zero_flag    = (track == 7'h00);
    assign inner_track_flag_n = (track < 7'h2c);
    // {transfer request, irq, write gate, step, direction}
    assign fc_lines           = pat;
endmodule

/* tb/dsc_regs_tb_top.sv */
// testbench: register accesses against the disk-side register bank
module dsc_regs_tb_top
    import dsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic       sys_clk = 0, nrst = 0, clk_en = 1, io_wr = 0, io_rd = 0, cpu_a15 = 0;
    logic       irqs_n = 1, irqm_n = 1, rn;
    logic [7:0] io_addr = 8'h00, io_wdata = 8'h00, io_rdata, d;
    logic [6:0] track = 7'h00;
    logic [4:0] pat = 5'h00, fcl;
    logic       mem_a15, flip, l0, l1, l2, fc_ready_n, m0n, m1n, side, rdy_n, tr0, inn_n;
    logic [1:0] ds, pc;
    int         num_errors = 0, samples_checked = 0, i;

    dsc_regs u_dut (.sys_clk, .nrst, .clk_en, .io_addr, .io_wdata, .io_wr, .io_rd, .cpu_a15,
        .irq_to_secondary_cpu_n(irqs_n), .irq_to_main_cpu_n(irqm_n), .drive_ready_n(rdy_n),
        .head_dir_n(fcl[0]), .track_zero_flag(tr0), .write_gate_n(fcl[2]),
        .head_step_n(fcl[1]), .inner_track_flag_n(inn_n), .fc_irq(fcl[3]),
        .transfer_request(fcl[4]), .io_rdata, .mem_a15, .addr_invert_bit(flip),
        .diag_lamp_lsb(l0), .diag_lamp_mid(l1), .diag_lamp_msb(l2), .drive_select_field(ds),
        .fc_ready_n, .motor0_on_n(m0n), .motor1_on_n(m1n), .side_select(side),
        .precomp_select(pc));
    dsc_far_model u_far (.drive_select_field(ds), .motor0_on_n(m0n), .motor1_on_n(m1n),
        .track, .pat, .drive_ready_n(rdy_n), .track_zero_flag(tr0),
        .inner_track_flag_n(inn_n), .fc_lines(fcl));

    always #20 sys_clk = ~sys_clk;

    task chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge sys_clk);
        io_addr = a; io_wdata = v; io_wr = 1;
        @(negedge sys_clk);
        io_wr = 0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge sys_clk);
        io_addr = a; io_rd = 1;
        @(negedge sys_clk);
        io_rd = 0;
        chk(io_rdata, exp);
    endtask
    function automatic logic [7:0] gstat(input logic f, input logic r);
        return {pat[1], pat[2], track == 7'h00, pat[0], r, irqm_n, irqs_n, f};
    endfunction
    task conclude;
        $display("checked %0d, mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ------------------------------------------------------------
    // sequences
    // ------------------------------------------------------------
    initial begin
        repeat (5000) @(posedge sys_clk);
        num_errors++;
        conclude;
    end
    initial begin
        repeat (16) @(negedge sys_clk);
        nrst = 1;
        chk({flip, l2, l1, l0, mem_a15, fc_ready_n, m1n, m0n}, 8'h7f);
        chk({ds, side, pc, 3'h0}, 8'h00);
        $display("reset test done");
        for (i = 0; i < 8; i++) begin
            cpu_a15 = i[1]; pat = 5'(i * 5); irqs_n = i[0]; irqm_n = i[1];
            // bit 7 written high on purpose: the flip must follow the address only
            wr(i[0] ? 8'h21 : 8'h20, {1'b1, i[2:0], 4'hf});
            chk({4'h0, flip, l2, l1, l0}, {4'h0, i[0], i[2:0]});
            @(negedge sys_clk);
            chk({7'h00, mem_a15}, {7'h00, i[0] ? cpu_a15 : ~cpu_a15});
            rd(8'h21, gstat(i[0], 1'b1));
        end
        rd(8'h20, 8'h00);
        rd(8'h55, 8'h00);
        $display("general register test done");
        for (i = 0; i < 8; i++) begin
            track = 7'(i * 11); pat = 5'(i * 3); irqs_n = i[1]; irqm_n = i[0];
            d = {1'b0, track > 7'h3c, i[2], i[1], i[0], i[2], i[1:0]};
            wr(DSC_DRV_OFS, d);
            chk({ds, side, pc, ~m1n, ~m0n, 1'b0}, {d[1:0], d[5], d[7:6], d[4:3], 1'b0});
            rn = d[1] ? ~d[4] : ~d[3];
            @(negedge sys_clk);
            chk({7'h00, fc_ready_n}, {7'h00, rn & ~d[2]});
            rd(DSC_DRV_OFS, {pat[4:3], d[5], ~d[4], ~d[3], track < 7'h2c, d[1:0]});
            rd(DSC_GEN_STAT_OFS, gstat(1'b1, rn));
        end
        $display("drive register test done");
        // writes while the enable is low must leave every register untouched
        clk_en = 0;
        wr(8'h20, 8'h00);
        wr(DSC_DRV_OFS, 8'h00);
        chk({4'h0, flip, l2, l1, l0}, 8'h0f);
        chk({ds, side, pc, ~m1n, ~m0n, 1'b0}, {d[1:0], d[5], d[7:6], d[4:3], 1'b0});
        clk_en = 1;
        $display("clock enable test done");
        @(negedge sys_clk);
        nrst = 0;
        @(negedge sys_clk);
        chk({flip, ds, m1n, m0n, pc, side}, 8'h18);
        chk({l2, l1, l0, mem_a15, fc_ready_n, 3'h0}, 8'hf8);
        nrst = 1;
        rd(DSC_DRV_OFS, {pat[4:3], 3'h3, track < 7'h2c, 2'h0});
        rd(DSC_GEN_STAT_OFS, gstat(1'b0, 1'b1));
        $display("second reset test done");
        conclude;
    end
endmodule
